/* File: rtl/tmr_consts.svh */
// constants for the dual timer and capture timer block
// assumes a single 10 MHz system clock; machine cycle is 12 (or 4) clocks
//
// Contract
// - timer counts at clock/12 or clock/4
// - sample count pin each machine cycle phase
// - count changes at one phase, next cycle
// - function select bits 2 and 6
// - four modes per counter from mode field
// - fast base bit, reset selects divide-by-12
// - mode 0 is 13 bits wide
// - mode 0 wrap 1FFF sets overflow flag
// - count only if run and gate allows
// - mode 1 sixteen bits, wrap sets flag
// - mode 2 low byte reloads from high
// - second counter frozen in mode 3
// - first counter splits in mode 3
// - second counter runs without run/flag then
// - third counter pin or divided clock, run
// - capture mode 16-bit wrap sets flag
// - capture pin edge copies count, sets flag
// - clear third counter after capture option
// - third interrupt is OR of flags
// - serviced interrupt clears overflow flags (counters 0 and 1 only here; counter 2 flags clear by software)
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define SLOW_DIV 4'hC
`define FAST_DIV 4'h4
`define PHASE_SAMPLE 4'h3
`define PHASE_UPDATE 4'h2
`define MODE_SEL0_CT 2
`define MODE_SEL1_CT 6
`define MODE_SEL0_GATE 3
`define MODE_SEL1_GATE 7
`define MODE_SEL0_LSB 0
`define MODE_SEL1_LSB 4
`define CNT2_CLR_BIT 3
`define BYTE_RST 8'h00
`define MODE0_LOW_MASK 8'h1F
`endif

/* File: rtl/tmr_pkg.sv */
// types for the dual timer and capture timer block
// assumes the constants header is included by users of the numbers
package tmr_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD, MODE_SPLIT} cnt_mode_e;
endpackage : tmr_pkg

/* File: rtl/tmr_prescale.sv */
// machine-cycle phase generator: sample and update strobes
// assumes i_clk is the system clock
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tmr_prescale (
  input wire logic i_clk,
  input wire logic i_resetn,
  tmr_tick_if.src tick
);
  import tmr_pkg::*;
  logic [3:0] ph12_ff;
  logic [1:0] ph4_ff;

  // twelve-clock machine cycle counter
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ph12_ff <= 4'h0;
    end else if (ph12_ff == `SLOW_DIV - 4'h1) begin
      ph12_ff <= 4'h0;
    end else begin
      ph12_ff <= ph12_ff + 4'h1;
    end
  end

  // four-clock turbo counter
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ph4_ff <= 2'h0;
    end else begin
      ph4_ff <= ph4_ff + 2'h1;
    end
  end

  // pins sample at one phase, counts move at another within the cycle
  assign tick.sample = (ph12_ff == `PHASE_SAMPLE);
  assign tick.upd_slow = (ph12_ff == `PHASE_UPDATE);
  assign tick.upd_fast = (ph4_ff == 2'h2);
endmodule : tmr_prescale

/* File: rtl/tmr_tick_if.sv */
// carries the time-base ticks from the prescaler to the counters
// assumes one producer and one consumer in the same clock domain
`timescale 1ns/100ps
interface tmr_tick_if;
  logic upd_slow;
  logic upd_fast;
  logic sample;
  modport src (output upd_slow, output upd_fast, output sample);
  modport dst (input upd_slow, input upd_fast, input sample);
endinterface : tmr_tick_if

/* File: rtl/tmr_top.sv */
// two mode-selectable timer/counters and a capture counter
// assumes pins are synchronous to i_clk; software writes arrive as one-cycle strobes
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tmr_top (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_counter_mode_reg,
  input wire logic i_cnt0_fast_base,
  input wire logic i_cnt1_fast_base,
  input wire logic i_cnt0_run,
  input wire logic i_cnt1_run,
  input wire logic i_cnt2_run,
  input wire logic i_cnt2_source_sel,
  input wire logic i_cnt2_fast_base,
  input wire logic i_capture_or_reload_sel,
  input wire logic i_cnt2_external_enable,
  input wire logic i_clear_after_capture,
  input wire logic i_gate_pin_a,
  input wire logic i_gate_pin_b,
  input wire logic i_count_pin_a,
  input wire logic i_count_pin_b,
  input wire logic i_count_pin_c,
  input wire logic i_capture_trigger_pin,
  input wire logic [2:0] i_wr_sel,
  input wire logic i_wr_en,
  input wire tmr_pkg::byte_t i_wr_data,
  input wire logic i_cnt0_int_ack,
  input wire logic i_cnt1_int_ack,
  input wire logic i_cnt2_ovf_clr,
  input wire logic i_cnt2_ext_clr,
  output logic [15:0] o_cnt0,
  output logic [15:0] o_cnt1,
  output logic [15:0] o_cnt2,
  output logic [15:0] o_capture,
  output logic o_cnt0_overflow_flag,
  output logic o_cnt1_overflow_flag,
  output logic o_cnt2_overflow_flag,
  output logic o_cnt2_external_flag,
  output logic o_cnt2_irq
);
  import tmr_pkg::*;

  tmr_tick_if tick();
  tmr_prescale u_pre (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .tick(tick)
  );

  // write select codes
  localparam logic [2:0] WS_C0L = 3'h0;
  localparam logic [2:0] WS_C0H = 3'h1;
  localparam logic [2:0] WS_C1L = 3'h2;
  localparam logic [2:0] WS_C1H = 3'h3;
  localparam logic [2:0] WS_C2L = 3'h4;
  localparam logic [2:0] WS_C2H = 3'h5;

  byte_t c0l_ff, c0h_ff, c1l_ff, c1h_ff, c2l_ff, c2h_ff, capl_ff, caph_ff;
  logic f0_ff, f1_ff, f2_ff, x2_ff, irq_ff;
  logic [3:0] smp_ff, edge_ff, pin_now;

  cnt_mode_e mode0, mode1;
  logic ct0, ct1, gate0, gate1;
  assign mode0 = cnt_mode_e'(i_counter_mode_reg[`MODE_SEL0_LSB +: 2]);
  assign mode1 = cnt_mode_e'(i_counter_mode_reg[`MODE_SEL1_LSB +: 2]);
  assign ct0 = i_counter_mode_reg[`MODE_SEL0_CT];
  assign ct1 = i_counter_mode_reg[`MODE_SEL1_CT];
  assign gate0 = i_counter_mode_reg[`MODE_SEL0_GATE];
  assign gate1 = i_counter_mode_reg[`MODE_SEL1_GATE];

  // time base tick for a timer, chosen by its fast base bit
  function automatic logic base_tick(input logic fast, input logic slow_t, input logic fast_t);
    base_tick = fast ? fast_t : slow_t;
  endfunction : base_tick

  // run qualifier shared by both first counters
  function automatic logic run_ok(input logic run, input logic gate, input logic pin);
    run_ok = run && (!gate || pin);
  endfunction : run_ok

  function automatic logic wr_hit(input logic en, input logic [2:0] sel, input logic [2:0] code);
    wr_hit = en && (sel == code);
  endfunction : wr_hit

  assign pin_now = {i_capture_trigger_pin, i_count_pin_c, i_count_pin_b, i_count_pin_a};

  // pin samples once per machine cycle; index 3 is the capture trigger
  // reset to low so a pin that is low after reset cannot fake a falling edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      smp_ff <= 4'h0;
    end else if (tick.sample) begin
      smp_ff <= pin_now;
    end
  end

  // edge from last cycle's sample and this one, held until the next update phase
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      edge_ff <= 4'h0;
    end else if (tick.sample) begin
      edge_ff <= smp_ff & ~pin_now;
    end else if (tick.upd_slow) begin
      edge_ff <= 4'h0;
    end
  end

  // counter edges only land on the slow update phase since pins move per machine cycle
  logic inc0, inc1, inc0h, inc2, cap_ev;
  logic t0_step, t1_step;
  assign t0_step = ct0 ? (tick.upd_slow && edge_ff[0]) : base_tick(i_cnt0_fast_base, tick.upd_slow, tick.upd_fast);
  assign t1_step = ct1 ? (tick.upd_slow && edge_ff[1]) : base_tick(i_cnt1_fast_base, tick.upd_slow, tick.upd_fast);
  assign inc0 = t0_step && run_ok(i_cnt0_run, gate0, i_gate_pin_a);
  // in split mode the high half of counter 0 borrows counter 1's run bit
  assign inc0h = (mode0 == MODE_SPLIT) && i_cnt1_run &&
                 base_tick(i_cnt0_fast_base, tick.upd_slow, tick.upd_fast);
  // with counter 0 split, counter 1 ignores its run bit but still obeys its gate, and stops in its own mode 3
  assign inc1 = t1_step && (mode1 != MODE_SPLIT) &&
                ((mode0 == MODE_SPLIT) ? (!gate1 || i_gate_pin_b)
                                      : run_ok(i_cnt1_run, gate1, i_gate_pin_b));
  assign inc2 = i_cnt2_run && (i_cnt2_source_sel ? (tick.upd_slow && edge_ff[2])
               : base_tick(i_cnt2_fast_base, tick.upd_slow, tick.upd_fast));
  assign cap_ev = i_capture_or_reload_sel && i_cnt2_external_enable && tick.upd_slow && edge_ff[3];

  // next values for a mode 0-2 counter; ovf reports the wrap
  function automatic logic [16:0] step16(input cnt_mode_e m, input byte_t lo, input byte_t hi);
    logic [16:0] r;
    logic [4:0] l5;
    r = {1'b0, hi, lo};
    l5 = lo[4:0] + 5'h01;
    case (m)
      MODE_13BIT: begin
        // upper three low-byte bits are left alone
        r[7:0] = {lo[7:5], l5};
        if (lo[4:0] == 5'h1F) begin
          r[15:8] = hi + 8'h01;
          r[16] = (hi == 8'hFF);
        end
      end
      MODE_16BIT: begin
        r = {1'b0, hi, lo} + 17'h00001;
      end
      default: begin
        if (lo == 8'hFF) begin
          r[7:0] = hi;
          r[16] = 1'b1;
        end else begin
          r[7:0] = lo + 8'h01;
        end
      end
    endcase
    step16 = r;
  endfunction : step16

  logic [16:0] n0, n1;
  assign n0 = step16(mode0, c0l_ff, c0h_ff);
  assign n1 = step16(mode1, c1l_ff, c1h_ff);
  logic ovf0, ovf0h, ovf1;
  assign ovf0 = inc0 && ((mode0 == MODE_SPLIT) ? (c0l_ff == 8'hFF) : n0[16]);
  assign ovf0h = inc0h && (c0h_ff == 8'hFF);
  assign ovf1 = inc1 && n1[16];

  // counter 0 bytes; a software write wins over a count
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      c0l_ff <= `BYTE_RST;
      c0h_ff <= `BYTE_RST;
    end else begin
      if (wr_hit(i_wr_en, i_wr_sel, WS_C0L)) begin
        c0l_ff <= i_wr_data;
      end else if (inc0) begin
        c0l_ff <= (mode0 == MODE_SPLIT) ? c0l_ff + 8'h01 : n0[7:0];
      end
      if (wr_hit(i_wr_en, i_wr_sel, WS_C0H)) begin
        c0h_ff <= i_wr_data;
      end else if (mode0 == MODE_SPLIT) begin
        if (inc0h) begin
          c0h_ff <= c0h_ff + 8'h01;
        end
      end else if (inc0) begin
        c0h_ff <= n0[15:8];
      end
    end
  end

  // counter 1 bytes
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      c1l_ff <= `BYTE_RST;
      c1h_ff <= `BYTE_RST;
    end else begin
      if (wr_hit(i_wr_en, i_wr_sel, WS_C1L)) begin
        c1l_ff <= i_wr_data;
      end else if (inc1) begin
        c1l_ff <= n1[7:0];
      end
      if (wr_hit(i_wr_en, i_wr_sel, WS_C1H)) begin
        c1h_ff <= i_wr_data;
      end else if (inc1) begin
        c1h_ff <= n1[15:8];
      end
    end
  end

  // overflow flags: a set in the same cycle as service beats the clear
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      f0_ff <= 1'b0;
      f1_ff <= 1'b0;
    end else begin
      if (ovf0) begin
        f0_ff <= 1'b1;
      end else if (i_cnt0_int_ack) begin
        f0_ff <= 1'b0;
      end
      // counter 1 loses its flag to the split high half of counter 0
      if ((mode0 == MODE_SPLIT) ? ovf0h : ovf1) begin
        f1_ff <= 1'b1;
      end else if (i_cnt1_int_ack) begin
        f1_ff <= 1'b0;
      end
    end
  end

  // counter 2: capture clear beats a write and a count
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      c2l_ff <= `BYTE_RST;
      c2h_ff <= `BYTE_RST;
    end else if (cap_ev && i_clear_after_capture) begin
      c2l_ff <= `BYTE_RST;
      c2h_ff <= `BYTE_RST;
    end else begin
      if (wr_hit(i_wr_en, i_wr_sel, WS_C2L)) begin
        c2l_ff <= i_wr_data;
      end else if (inc2) begin
        c2l_ff <= c2l_ff + 8'h01;
      end
      if (wr_hit(i_wr_en, i_wr_sel, WS_C2H)) begin
        c2h_ff <= i_wr_data;
      end else if (inc2 && c2l_ff == 8'hFF) begin
        c2h_ff <= c2h_ff + 8'h01;
      end
    end
  end

  // capture registers snapshot the count as it stood
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      capl_ff <= `BYTE_RST;
      caph_ff <= `BYTE_RST;
    end else if (cap_ev) begin
      capl_ff <= c2l_ff;
      caph_ff <= c2h_ff;
    end
  end

  // counter 2 flags are never cleared by service, only by software
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      f2_ff <= 1'b0;
      x2_ff <= 1'b0;
    end else begin
      if (i_capture_or_reload_sel && inc2 && {c2h_ff, c2l_ff} == 16'hFFFF) begin
        f2_ff <= 1'b1;
      end else if (i_cnt2_ovf_clr) begin
        f2_ff <= 1'b0;
      end
      if (cap_ev) begin
        x2_ff <= 1'b1;
      end else if (i_cnt2_ext_clr) begin
        x2_ff <= 1'b0;
      end
    end
  end

  // interrupt request lags the flags by one clock so the output is registered
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= f2_ff || x2_ff;
    end
  end

  assign o_cnt0 = {c0h_ff, c0l_ff};
  assign o_cnt1 = {c1h_ff, c1l_ff};
  assign o_cnt2 = {c2h_ff, c2l_ff};
  assign o_capture = {caph_ff, capl_ff};
  assign o_cnt0_overflow_flag = f0_ff;
  assign o_cnt1_overflow_flag = f1_ff;
  assign o_cnt2_overflow_flag = f2_ff;
  assign o_cnt2_external_flag = x2_ff;
  assign o_cnt2_irq = irq_ff;
endmodule : tmr_top

/* File: verification/dual_timer_and_capture_timer_tb.sv */
// self-checking bench for the timer block
// assumes tmr_top, its package, the checker and the pin model are compiled first
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module dual_timer_and_capture_timer_tb;
  import tmr_pkg::*;
  logic clk, rstn, f0, f1, f2, r0, r1, r2, src, cap, ext, clr, ga, gb, we, ack0, ack1, oc, ec;
  logic [7:0] mode;
  logic [2:0] sel;
  byte_t wd;
  logic [3:0] req, pins, flg;
  logic [15:0] c0, c1, c2, capv, v;
  logic fo0, fo1, fo2, fe, irq;
  int bad_count, compares, g;
  assign flg = {fe, fo2, fo1, fo0};

  tmr_top i_tmr_top (.i_clk(clk), .i_resetn(rstn), .i_counter_mode_reg(mode), .i_cnt0_fast_base(f0),
    .i_cnt1_fast_base(f1), .i_cnt0_run(r0), .i_cnt1_run(r1), .i_cnt2_run(r2), .i_cnt2_source_sel(src),
    .i_cnt2_fast_base(f2), .i_capture_or_reload_sel(cap), .i_cnt2_external_enable(ext),
    .i_clear_after_capture(clr), .i_gate_pin_a(ga), .i_gate_pin_b(gb), .i_count_pin_a(pins[0]),
    .i_count_pin_b(pins[1]), .i_count_pin_c(pins[2]), .i_capture_trigger_pin(pins[3]), .i_wr_sel(sel),
    .i_wr_en(we), .i_wr_data(wd), .i_cnt0_int_ack(ack0), .i_cnt1_int_ack(ack1), .i_cnt2_ovf_clr(oc),
    .i_cnt2_ext_clr(ec), .o_cnt0(c0), .o_cnt1(c1), .o_cnt2(c2), .o_capture(capv),
    .o_cnt0_overflow_flag(fo0), .o_cnt1_overflow_flag(fo1), .o_cnt2_overflow_flag(fo2),
    .o_cnt2_external_flag(fe), .o_cnt2_irq(irq));
  tmr_pin_model i_tmr_pin_model (.i_clk(clk), .i_pulse_req(req), .o_pins(pins));

  // 100 ns system clock
  always #50 clk = ~clk;

  // inputs always move 1 ns after the edge so the design never races the bench
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] s, input byte_t d);
    sel = s;
    wd = d;
    we = 1'b1;
    tick(1);
    we = 1'b0;
    tick(1);
  endtask : wr

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse

  task automatic pin(input logic [3:0] p);
    req = p;
    tick(1);
    req = 4'h0;
    tick(60);
  endtask : pin

  task automatic wait_flag(input int k, input int n);
    for (int i = 0; i < n && flg[k] !== 1'b1; i++) tick(1);
  endtask : wait_flag

  // clocks between two steps of counter 0; the first loop only syncs
  task automatic gap();
    repeat (2) begin
      v = c0;
      g = 0;
      while (c0 === v && g < 40) begin
        tick(1);
        g++;
      end
    end
  endtask : gap

  task automatic t_time_base();
    `CHK("cnt0 reset", 16'h0000, c0)
    `CHK("flags reset", 4'h0, flg)
    mode = 8'h01;
    r0 = 1'b1;
    gap();
    `CHK("slow gap", 12, g)
    f0 = 1'b1;
    gap();
    `CHK("fast gap", 4, g)
    f0 = 1'b0;
    r0 = 1'b0;
    $display("test time_base done");
  endtask : t_time_base

  // preload near the top, run to the wrap, then service the flag
  task automatic t_wrap(input logic [7:0] m, input byte_t hi, input byte_t lo, input logic [15:0] e);
    mode = m;
    wr(3'h1, hi);
    wr(3'h0, lo);
    `CHK("preload", {hi, lo}, c0)
    r0 = 1'b1;
    wait_flag(0, 60);
    r0 = 1'b0;
    `CHK("wrap flag", 1'b1, fo0)
    `CHK("wrap value", e, c0)
    pulse(ack0);
    `CHK("serviced", 1'b0, fo0)
    $display("test wrap mode %0h done", m);
  endtask : t_wrap

  task automatic t_gate();
    mode = 8'h09;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    r0 = 1'b1;
    tick(40);
    `CHK("gate low", 16'h0000, c0)
    ga = 1'b1;
    tick(40);
    `CHK("gate high", 1'b1, c0 != 16'h0000)
    r0 = 1'b0;
    ga = 1'b0;
    $display("test gate done");
  endtask : t_gate

  task automatic t_pins();
    mode = 8'h55;
    for (int s = 0; s < 4; s++) wr(3'(s), 8'h00);
    r0 = 1'b1;
    r1 = 1'b1;
    tick(40);
    `CHK("no edge no count", 32'h0, {c0, c1})
    pin(4'h3);
    `CHK("one edge each", 32'h00010001, {c0, c1})
    r0 = 1'b0;
    r1 = 1'b0;
    $display("test pins done");
  endtask : t_pins

  task automatic t_split();
    mode = 8'h33;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h34);
    wr(3'h3, 8'h12);
    r1 = 1'b1;
    tick(40);
    `CHK("low half idle", 8'h00, c0[7:0])
    `CHK("high half runs", 1'b1, c0[15:8] != 8'h00)
    `CHK("cnt1 frozen", 16'h1234, c1)
    wr(3'h1, 8'hFF);
    wait_flag(1, 40);
    `CHK("high half flag", 2'b10, {fo1, fo0})
    pulse(ack1);
    mode = 8'h13;
    r1 = 1'b0;
    tick(40);
    `CHK("cnt1 runs alone", 1'b1, c1 != 16'h1234)
    mode = 8'h00;
    $display("test split done");
  endtask : t_split

  task automatic t_capture();
    cap = 1'b1;
    ext = 1'b1;
    wr(3'h4, 8'hF0);
    wr(3'h5, 8'hFF);
    r2 = 1'b1;
    wait_flag(2, 300);
    `CHK("cnt2 wrap", 2'b01, {fe, fo2})
    tick(1);
    `CHK("irq from wrap", 1'b1, irq)
    pulse(oc);
    tick(1);
    `CHK("software clear", 2'b00, {fo2, irq})
    src = 1'b1;
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    pin(4'h4);
    `CHK("pin count", 16'h0001, c2)
    clr = 1'b1;
    pin(4'h8);
    `CHK("captured", 16'h0001, capv)
    `CHK("cleared", 16'h0000, c2)
    `CHK("ext flag irq", 2'b11, {fe, irq})
    pulse(ec);
    r2 = 1'b0;
    $display("test capture done");
  endtask : t_capture

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // a hang costs one mismatch and ends the run the normal way
  initial begin
    #(100 * 8000);
    bad_count++;
    finish_test();
  end

  // reset for 20 clocks, then the scenarios in turn
  initial begin
    {clk, rstn, f0, f1, f2, r0, r1, r2, src, cap, ext, clr, ga, gb, we, ack0, ack1, oc, ec} = '0;
    {mode, sel, wd, req} = '0;
    tick(20);
    rstn = 1'b1;
    tick(2);
    t_time_base();
    t_wrap(8'h01, 8'hFF, 8'hFE, 16'h0000);
    t_wrap(8'h00, 8'hFF, 8'hFF, 16'h00E0);
    t_wrap(8'h02, 8'h80, 8'hFF, 16'h8080);
    t_gate();
    t_pins();
    t_split();
    t_capture();
    finish_test();
  end
endmodule : dual_timer_and_capture_timer_tb

/* File: verification/tmr_pin_model.sv */
// outside source for the count and capture pins
// assumes a one-clock request per falling edge wanted; pins idle high
`timescale 1ns/100ps
module tmr_pin_model (
  input wire logic i_clk,
  input wire logic [3:0] i_pulse_req,
  output logic [3:0] o_pins
);
  int left [4] = '{0, 0, 0, 0};
  logic [3:0] req;
  initial o_pins = 4'hF;
  // 12 clocks low then at least 13 high: edges never come faster than clock/24
  always @(posedge i_clk) begin
    req = i_pulse_req;
    #1;
    for (int i = 0; i < 4; i++) begin
      if (left[i] == 0 && req[i]) left[i] = 24;
      else if (left[i] > 0) left[i] = left[i] - 1;
      o_pins[i] = !(left[i] > 12);
    end
  end
endmodule : tmr_pin_model

/* File: verification/tmr_top_assertions.sv */
// port-level checker for the timer block, bound into tmr_top
// assumes one clock domain and the active-low asynchronous reset of the top
`timescale 1ns/100ps
module tmr_top_checker (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_counter_mode_reg,
  input wire logic i_cnt0_run,
  input wire logic i_cnt2_run,
  input wire logic i_clear_after_capture,
  input wire logic [2:0] i_wr_sel,
  input wire logic i_wr_en,
  input wire tmr_pkg::byte_t i_wr_data,
  input wire logic i_cnt0_int_ack,
  input wire logic [15:0] o_cnt0,
  input wire logic [15:0] o_cnt1,
  input wire logic [15:0] o_cnt2,
  input wire logic [15:0] o_capture,
  input wire logic o_cnt0_overflow_flag,
  input wire logic o_cnt2_overflow_flag,
  input wire logic o_cnt2_external_flag,
  input wire logic o_cnt2_irq
);
  import tmr_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // software writes land one clock later, even over a hardware step
  AST_WR_LOW0: assert property (i_wr_en && i_wr_sel == 3'h0 |=> o_cnt0[7:0] == $past(i_wr_data))
    else $error("low byte write lost");
  AST_WR_HIGH1: assert property (i_wr_en && i_wr_sel == 3'h3 |=> o_cnt1[15:8] == $past(i_wr_data))
    else $error("high byte write lost");
  // counters hold when stopped; split mode is left out since run1 drives the high half
  AST_CNT0_IDLE: assert property (!i_cnt0_run && !i_wr_en && i_counter_mode_reg[1:0] != 2'h3 |=> $stable(o_cnt0))
    else $error("stopped counter moved");
  AST_CNT1_FROZEN: assert property (i_counter_mode_reg[5:4] == 2'h3 && !i_wr_en |=> $stable(o_cnt1))
    else $error("frozen counter moved");
  AST_CNT2_IDLE: assert property (!i_cnt2_run && !i_wr_en && !i_clear_after_capture |=> $stable(o_cnt2))
    else $error("stopped capture counter moved");
  // in mode 1 a rising flag means the full 16 bits just wrapped to zero
  AST_OVF0_WRAP: assert property ($rose(o_cnt0_overflow_flag) && i_counter_mode_reg[1:0] == 2'h1
    && !$past(i_wr_en) |-> o_cnt0 == 16'h0000)
    else $error("flag without wrap");
  AST_ACK_ONLY: assert property ($fell(o_cnt0_overflow_flag) |-> $past(i_cnt0_int_ack))
    else $error("flag dropped without service");
  // capture registers only move together with the external flag
  AST_CAP_FLAG: assert property ($changed(o_capture) |-> o_cnt2_external_flag)
    else $error("capture without flag");
  AST_CLR_AFTER: assert property ($rose(o_cnt2_external_flag) && $past(i_clear_after_capture)
    |-> o_cnt2 == 16'h0000)
    else $error("count not cleared");
  AST_IRQ_OR: assert property (o_cnt2_irq == $past(o_cnt2_overflow_flag | o_cnt2_external_flag))
    else $error("irq not flag or");

  cover property ($rose(o_cnt0_overflow_flag));
  cover property ($rose(o_cnt2_external_flag) && o_cnt2 == 16'h0000);
  cover property (i_counter_mode_reg[5:4] == 2'h3 && o_cnt0[15:8] != 8'h00);
endmodule : tmr_top_checker

bind tmr_top tmr_top_checker i_tmr_top_checker (.*);
